/* File: hw/fsc_regs.sv */
// Flash status, fault-injection and configuration registers behind an APB slave
//
// Contract
// - Force-double bit makes every read flag double
// - Force-single bit sets single flag, may interrupt
// - Force bits clear only by writing zero
// - Wait code 00 maximum at reset, 11 disables
// - Codes 01 and 10 read back, act as 00
// - Maximum wait inserts one cycle per read
// - Single-fault interrupt follows flag when enabled
// - Error-configuration assigned bits are read-write
// - Writing one launches; flag low until completion
// - Access error set on violations, blocks launch
// - Access and protection errors clear on one
// - Protection violation flag set, blocks launch, sequence
// - Busy reads one while command executes
// - Status bit 2 always reads zero
// - Completion status set on error, cleared on launch
// - Status writable, read-only and zero bits
// - Reset-sequence double fault alters status reset
// - Wait field write ignored while command runs
// - Command-complete interrupt follows flag when enabled
// - Fault flags clear only on writing one
// - Ignore-single suppresses single flag and interrupt
`timescale 1ns/1ps
module fsc_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Command sequencer side
  input wire fsc_pkg::fsc_cmd_event_type cmd_event_in,
  output logic cmd_launch_out,
  output logic seq_allowed_out,
  // Reset sequence side
  input wire logic reset_seq_done_in,
  input wire logic reset_seq_double_fault_in,
  input wire logic reset_seq_error_in,
  // Flash array read side
  input wire fsc_pkg::fsc_read_event_type read_event_in,
  output logic read_ready_out,
  output logic [1:0] wait_state_eff_out,
  // Interrupt requests
  output logic cmd_complete_irq_out,
  output logic single_fault_irq_out
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic command_complete_irq_enable_q;
  logic ignore_single_fault_q;
  logic [1:0] wait_state_select_q;
  logic force_double_fault_q;
  logic force_single_fault_q;
  logic single_fault_irq_enable_q;
  logic command_complete_flag_q;
  logic access_error_flag_q;
  logic protection_violation_flag_q;
  logic controller_busy_flag_q;
  logic [1:0] completion_status_bits_q;
  logic double_fault_flag_q;
  logic single_fault_flag_q;
  logic reset_seq_seen_q;
  logic rd_pending_q;
  logic [3:0] wait_cnt_q;
  logic [31:0] prdata_q;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] reg_addr);
    hit = (a == ADDR_W'(reg_addr));
  endfunction

  logic access;
  logic wr;
  logic wr_lane0;
  logic wr_config;
  logic wr_err_config;
  logic wr_status;
  logic wr_err_status;
  logic mapped;
  logic [7:0] wbyte;

  assign access = psel_in && penable_in;
  assign wr = access && pwrite_in && clk_en_in;
  assign wr_lane0 = wr && pstrb_in[0];
  assign wbyte = pwdata_in[7:0];
  assign wr_config = wr_lane0 && hit(paddr_in, fsc_pkg::ADDR_CONFIG);
  assign wr_err_config = wr_lane0 && hit(paddr_in, fsc_pkg::ADDR_ERR_CONFIG);
  assign wr_status = wr_lane0 && hit(paddr_in, fsc_pkg::ADDR_CMD_STATUS);
  assign wr_err_status = wr_lane0 && hit(paddr_in, fsc_pkg::ADDR_ERR_STATUS);
  assign mapped = hit(paddr_in, fsc_pkg::ADDR_CONFIG) || hit(paddr_in, fsc_pkg::ADDR_ERR_CONFIG) ||
                  hit(paddr_in, fsc_pkg::ADDR_CMD_STATUS) || hit(paddr_in, fsc_pkg::ADDR_ERR_STATUS);

  // Zero-wait slave; freezes with the clock enable
  assign pready_out = clk_en_in;
  assign pslverr_out = access && !mapped;

  // ------------------------------------------------------------
  // Command launch qualification
  // ------------------------------------------------------------
  logic launch;
  assign launch = wr_status && wbyte[fsc_pkg::ST_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag_q &&
                  !access_error_flag_q && !protection_violation_flag_q;
  assign cmd_launch_out = launch;
  assign seq_allowed_out = !protection_violation_flag_q;

  // ------------------------------------------------------------
  // Configuration register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      command_complete_irq_enable_q <= fsc_pkg::CONFIG_RESET[fsc_pkg::CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT];
      ignore_single_fault_q <= fsc_pkg::CONFIG_RESET[fsc_pkg::CFG_IGNORE_SINGLE_FAULT_BIT];
      wait_state_select_q <= fsc_pkg::WAIT_MAX;
      force_double_fault_q <= fsc_pkg::CONFIG_RESET[fsc_pkg::CFG_FORCE_DOUBLE_FAULT_BIT];
      force_single_fault_q <= fsc_pkg::CONFIG_RESET[fsc_pkg::CFG_FORCE_SINGLE_FAULT_BIT];
    end else if (wr_config) begin
      command_complete_irq_enable_q <= wbyte[fsc_pkg::CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT];
      ignore_single_fault_q <= wbyte[fsc_pkg::CFG_IGNORE_SINGLE_FAULT_BIT];
      // Reserved codes are stored as written
      if (command_complete_flag_q) begin
        wait_state_select_q <= wbyte[fsc_pkg::CFG_WAIT_LSB +: 2];
      end
      // Only an explicit write changes them; reads have no side effect
      force_double_fault_q <= wbyte[fsc_pkg::CFG_FORCE_DOUBLE_FAULT_BIT];
      force_single_fault_q <= wbyte[fsc_pkg::CFG_FORCE_SINGLE_FAULT_BIT];
    end
  end

  // ------------------------------------------------------------
  // Error configuration register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      single_fault_irq_enable_q <= fsc_pkg::ERR_CONFIG_RESET[fsc_pkg::ECFG_SINGLE_FAULT_IRQ_ENABLE_BIT];
    end else if (wr_err_config) begin
      single_fault_irq_enable_q <= wbyte[fsc_pkg::ECFG_SINGLE_FAULT_IRQ_ENABLE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Command status flags
  // ------------------------------------------------------------
  logic cmd_violation;
  assign cmd_violation = cmd_event_in.seq_violation || cmd_event_in.illegal_cmd;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      command_complete_flag_q <= 1'b0;
    end else if (clk_en_in) begin
      // Flag stays low from reset until the reset sequence finishes or a done or violation event arrives
      if (reset_seq_done_in && !reset_seq_seen_q) begin
        command_complete_flag_q <= 1'b1;
      end else if (launch) begin
        command_complete_flag_q <= 1'b0;
      end else if (!command_complete_flag_q && (cmd_event_in.done || cmd_violation)) begin
        command_complete_flag_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reset_seq_seen_q <= 1'b0;
    end else if (clk_en_in && reset_seq_done_in) begin
      reset_seq_seen_q <= 1'b1;
    end
  end

  // Event set wins over a simultaneous write-one clear
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      access_error_flag_q <= 1'b0;
    end else if (clk_en_in) begin
      if (cmd_violation) begin
        access_error_flag_q <= 1'b1;
      end else if (wr_status && wbyte[fsc_pkg::ST_ACCESS_ERROR_FLAG_BIT]) begin
        access_error_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      protection_violation_flag_q <= 1'b0;
    end else if (clk_en_in) begin
      if (cmd_event_in.prot_violation) begin
        protection_violation_flag_q <= 1'b1;
      end else if (wr_status && wbyte[fsc_pkg::ST_PROTECTION_VIOLATION_FLAG_BIT]) begin
        protection_violation_flag_q <= 1'b0;
      end
    end
  end

  // Busy from a launch or start event until completion or violation
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      controller_busy_flag_q <= 1'b0;
    end else if (clk_en_in) begin
      if (launch || cmd_event_in.start) begin
        controller_busy_flag_q <= 1'b1;
      end else if (cmd_event_in.done || cmd_violation) begin
        controller_busy_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      completion_status_bits_q <= fsc_pkg::COMPL_STATUS_RESET;
    end else if (clk_en_in) begin
      if (reset_seq_done_in && !reset_seq_seen_q) begin
        // A reset-sequence double fault shows in the status value
        completion_status_bits_q <= {reset_seq_double_fault_in, reset_seq_error_in};
      end else if (launch) begin
        completion_status_bits_q <= 2'h0;
      end else if (cmd_event_in.exec_error && controller_busy_flag_q) begin
        completion_status_bits_q <= 2'h3;
      end
    end
  end

  // ------------------------------------------------------------
  // Flash array reads: wait states and fault flags
  // ------------------------------------------------------------
  logic wait_enabled;
  logic read_done;
  assign wait_enabled = (wait_state_select_q != fsc_pkg::WAIT_OFF);
  assign read_done = read_event_in.req && (!wait_enabled || rd_pending_q);
  assign read_ready_out = read_done;
  assign wait_state_eff_out = wait_enabled ? fsc_pkg::WAIT_MAX : fsc_pkg::WAIT_OFF;

  // One inserted cycle per read at the maximum setting
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_pending_q <= 1'b0;
      wait_cnt_q <= 4'h0;
    end else if (clk_en_in) begin
      if (read_done) begin
        rd_pending_q <= 1'b0;
        wait_cnt_q <= 4'h0;
      end else if (read_event_in.req && wait_enabled) begin
        if (wait_cnt_q + 4'h1 >= fsc_pkg::WAIT_CYCLES) begin
          rd_pending_q <= 1'b1;
        end
        wait_cnt_q <= wait_cnt_q + 4'h1;
      end
    end
  end

  logic set_double;
  logic set_single;
  assign set_double = read_done && (force_double_fault_q || read_event_in.double_fault);
  assign set_single = read_done && !ignore_single_fault_q &&
                      (force_single_fault_q || read_event_in.single_fault);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      double_fault_flag_q <= 1'b0;
      single_fault_flag_q <= 1'b0;
    end else if (clk_en_in) begin
      if (set_double) begin
        double_fault_flag_q <= 1'b1;
      end else if (wr_err_status && wbyte[fsc_pkg::EST_DOUBLE_FAULT_FLAG_BIT]) begin
        double_fault_flag_q <= 1'b0;
      end
      if (set_single) begin
        single_fault_flag_q <= 1'b1;
      end else if (wr_err_status && wbyte[fsc_pkg::EST_SINGLE_FAULT_FLAG_BIT]) begin
        single_fault_flag_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt requests
  // ------------------------------------------------------------
  assign single_fault_irq_out = single_fault_flag_q && single_fault_irq_enable_q;
  assign cmd_complete_irq_out = command_complete_flag_q && command_complete_irq_enable_q;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit(paddr_in, fsc_pkg::ADDR_CONFIG)) begin
      rd_byte[fsc_pkg::CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT] = command_complete_irq_enable_q;
      rd_byte[fsc_pkg::CFG_IGNORE_SINGLE_FAULT_BIT] = ignore_single_fault_q;
      rd_byte[fsc_pkg::CFG_WAIT_LSB +: 2] = wait_state_select_q;
      rd_byte[fsc_pkg::CFG_FORCE_DOUBLE_FAULT_BIT] = force_double_fault_q;
      rd_byte[fsc_pkg::CFG_FORCE_SINGLE_FAULT_BIT] = force_single_fault_q;
    end else if (hit(paddr_in, fsc_pkg::ADDR_ERR_CONFIG)) begin
      rd_byte[fsc_pkg::ECFG_SINGLE_FAULT_IRQ_ENABLE_BIT] = single_fault_irq_enable_q;
    end else if (hit(paddr_in, fsc_pkg::ADDR_CMD_STATUS)) begin
      rd_byte[fsc_pkg::ST_COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag_q;
      rd_byte[fsc_pkg::ST_ACCESS_ERROR_FLAG_BIT] = access_error_flag_q;
      rd_byte[fsc_pkg::ST_PROTECTION_VIOLATION_FLAG_BIT] = protection_violation_flag_q;
      rd_byte[fsc_pkg::ST_BUSY_BIT] = controller_busy_flag_q;
      rd_byte[fsc_pkg::ST_RSVD_BIT] = 1'b0;
      rd_byte[1:0] = completion_status_bits_q;
    end else if (hit(paddr_in, fsc_pkg::ADDR_ERR_STATUS)) begin
      rd_byte[fsc_pkg::EST_DOUBLE_FAULT_FLAG_BIT] = double_fault_flag_q;
      rd_byte[fsc_pkg::EST_SINGLE_FAULT_FLAG_BIT] = single_fault_flag_q;
    end
  end

  // Registered on the setup cycle so data is stable in the access phase
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en_in && psel_in && !penable_in && !pwrite_in) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end
  assign prdata_out = prdata_q;

endmodule

/* File: hw/fsc_pkg.sv */
// Package of register map, field positions and timing counts for the flash status and fault block
package fsc_pkg;
  // Printed offsets are not multiples of four: they are word indices
  localparam logic [7:0] IDX_CONFIG = 8'h04;
  localparam logic [7:0] IDX_ERR_CONFIG = 8'h05;
  localparam logic [7:0] IDX_CMD_STATUS = 8'h06;
  localparam logic [7:0] IDX_ERR_STATUS = 8'h07;
  localparam logic [11:0] ADDR_CONFIG = {2'h0, IDX_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_ERR_CONFIG = {2'h0, IDX_ERR_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_CMD_STATUS = {2'h0, IDX_CMD_STATUS, 2'h0};
  localparam logic [11:0] ADDR_ERR_STATUS = {2'h0, IDX_ERR_STATUS, 2'h0};
  // flash_config fields
  localparam int CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT = 7;
  localparam int CFG_IGNORE_SINGLE_FAULT_BIT = 4;
  localparam int CFG_WAIT_LSB = 2;
  localparam int CFG_FORCE_DOUBLE_FAULT_BIT = 1;
  localparam int CFG_FORCE_SINGLE_FAULT_BIT = 0;
  // flash_error_config fields
  localparam int ECFG_SINGLE_FAULT_IRQ_ENABLE_BIT = 0;
  // flash_command_status fields
  localparam int ST_COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int ST_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int ST_PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_RSVD_BIT = 2;
  // flash_error_status fields
  localparam int EST_DOUBLE_FAULT_FLAG_BIT = 1;
  localparam int EST_SINGLE_FAULT_FLAG_BIT = 0;
  // Wait-state codes and reset values
  localparam logic [1:0] WAIT_MAX = 2'h0;
  localparam logic [1:0] WAIT_OFF = 2'h3;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] ERR_CONFIG_RESET = 8'h00;
  localparam logic [1:0] COMPL_STATUS_RESET = 2'h0;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WAIT_TIME_NS = 5;
  localparam int WAIT_CYCLES_RAW = (WAIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] WAIT_CYCLES = (WAIT_CYCLES_RAW < 1) ? 4'h1 : 4'(WAIT_CYCLES_RAW);

  typedef struct packed {
    logic start;
    logic done;
    logic seq_violation;
    logic illegal_cmd;
    logic prot_violation;
    logic exec_error;
  } fsc_cmd_event_type;

  typedef struct packed {
    logic req;
    logic single_fault;
    logic double_fault;
  } fsc_read_event_type;
endpackage

/* File: sim/fsc_regs_monitor.sv */
// Assertion checker for the flash status and fault register block
`timescale 1ns/1ps
module fsc_regs_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [31:0] prdata_out,
  input wire fsc_pkg::fsc_cmd_event_type cmd_event_in,
  input wire logic cmd_launch_out,
  input wire logic seq_allowed_out,
  input wire fsc_pkg::fsc_read_event_type read_event_in,
  input wire logic read_ready_out,
  input wire logic [1:0] wait_state_eff_out,
  input wire logic cmd_complete_irq_out,
  input wire logic single_fault_irq_out
);
  // ----------------------------------------
  // Command in flight, ended by done, a sequence violation or an illegal command (not a protection violation)
  // ----------------------------------------
  logic running_q;
  logic acc;
  logic mapped;
  assign acc = psel_in && penable_in;
  assign mapped = paddr_in inside {fsc_pkg::ADDR_CONFIG, fsc_pkg::ADDR_ERR_CONFIG,
    fsc_pkg::ADDR_CMD_STATUS, fsc_pkg::ADDR_ERR_STATUS};
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      running_q <= 1'b0;
    end else if (clk_en_in && cmd_launch_out) begin
      running_q <= 1'b1;
    end else if (clk_en_in && (cmd_event_in.done || cmd_event_in.seq_violation || cmd_event_in.illegal_cmd)) begin
      running_q <= 1'b0;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_ready_tracks_en: assert property (pready_out == clk_en_in) else $error("pready not following enable");
  a_unmapped_error: assert property (acc && !mapped |-> pslverr_out) else $error("unmapped access without error");
  a_mapped_clean: assert property (acc && mapped |-> !pslverr_out) else $error("mapped access flagged as error");
  a_launch_cause: assert property (cmd_launch_out |-> acc && pwrite_in && pstrb_in[0] && seq_allowed_out
    && paddr_in == fsc_pkg::ADDR_CMD_STATUS && pwdata_in[7]) else $error("launch without a launching write");
  a_no_relaunch: assert property (running_q |-> !cmd_launch_out) else $error("launch while command runs");
  a_rsvd_reads_zero: assert property (acc && !pwrite_in && paddr_in == fsc_pkg::ADDR_CMD_STATUS
    |-> prdata_out[2] == 1'b0 && prdata_out[31:8] == 24'h0) else $error("reserved status bit nonzero");
  a_wait_eff_code: assert property (wait_state_eff_out inside {2'h0, 2'h3}) else $error("bad wait code");
  a_wait_off_fast: assert property (clk_en_in && read_event_in.req && wait_state_eff_out == 2'h3
    |-> read_ready_out) else $error("read delayed with waits off");
  a_wait_max_slow: assert property (clk_en_in && read_event_in.req && !$past(read_event_in.req)
    && wait_state_eff_out == 2'h0 |-> !read_ready_out ##1 read_ready_out) else $error("wait not one cycle");
endmodule
bind fsc_regs fsc_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .prdata_out(prdata_out), .cmd_event_in(cmd_event_in), .cmd_launch_out(cmd_launch_out),
  .seq_allowed_out(seq_allowed_out), .read_event_in(read_event_in), .read_ready_out(read_ready_out),
  .wait_state_eff_out(wait_state_eff_out), .cmd_complete_irq_out(cmd_complete_irq_out),
  .single_fault_irq_out(single_fault_irq_out));

/* File: sim/fsc_regs_test.sv */
// Self-checking testbench for the flash status and fault register block
`timescale 1ns/1ps
module fsc_regs_test;
  localparam logic [11:0] A_CF = fsc_pkg::ADDR_CONFIG;
  localparam logic [11:0] A_EC = fsc_pkg::ADDR_ERR_CONFIG;
  localparam logic [11:0] A_ST = fsc_pkg::ADDR_CMD_STATUS;
  localparam logic [11:0] A_ES = fsc_pkg::ADDR_ERR_STATUS;
  logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic seq_done = 1'b0, seq_df = 1'b0, seq_err = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, launch, seq_ok, rready, cc_irq, sf_irq;
  logic [1:0] wait_eff;
  logic [7:0] cfg;
  fsc_pkg::fsc_cmd_event_type cmd_ev = '0;
  fsc_pkg::fsc_read_event_type rd_ev = '0;
  logic [7:0] exp_q[$];
  int mismatches = 0, n_compared = 0, n_launch = 0, cyc = 0;
  always #2.5 clk = ~clk;
  fsc_regs #(.ADDR_W(12)) uut (.ref_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(clk_en), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .cmd_event_in(cmd_ev),
    .cmd_launch_out(launch), .seq_allowed_out(seq_ok), .reset_seq_done_in(seq_done),
    .reset_seq_double_fault_in(seq_df), .reset_seq_error_in(seq_err), .read_event_in(rd_ev),
    .read_ready_out(rready), .wait_state_eff_out(wait_eff), .cmd_complete_irq_out(cc_irq),
    .single_fault_irq_out(sf_irq));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'($urandom()), d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  task ev(input fsc_pkg::fsc_cmd_event_type e);
    @(posedge clk);
    cmd_ev <= e;
    @(posedge clk);
    cmd_ev <= '0;
  endtask
  task fread(input logic s, input logic d);
    @(posedge clk);
    rd_ev <= {1'b1, s, d};
    do @(posedge clk); while (rready !== 1'b1);
    rd_ev <= '0;
  endtask
  // ----------------------------------------
  // Output watcher: read data against the oldest note
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (psel && penable && pready && !pwrite) begin
      check(prdata, {24'h0, exp_q.pop_front()});
    end
    // Error response only for offsets outside the register map
    if (psel && penable && pready) begin
      check({31'h0, pslverr}, {31'h0, !(paddr inside {A_CF, A_EC, A_ST, A_ES})});
    end
    if (launch && clk_en) begin
      n_launch++;
    end
    if (cyc == 4000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    void'($urandom(32'habbec973));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(A_ST, 8'h00);
    rd(A_CF, 8'h00);
    rd(A_EC, 8'h00);
    @(posedge clk);
    seq_done <= 1'b1;
    seq_df <= 1'b1;
    @(posedge clk);
    seq_df <= 1'b0;
    rd(A_ST, 8'h82);
    wr(A_ST, 8'h4f);
    rd(A_ST, 8'h82);
    for (int c = 0; c < 4; c++) begin
      wr(A_CF, 8'(c << 2));
      rd(A_CF, 8'(c << 2));
      check({30'h0, wait_eff}, (c == 3) ? 32'h3 : 32'h0);
    end
    wr(A_CF, 8'hff);
    rd(A_CF, 8'h9f);
    check({31'h0, cc_irq}, 32'h1);
    cfg = 8'($urandom());
    wr(A_EC, cfg);
    rd(A_EC, cfg & 8'h01);
    wr(A_CF, 8'h80);
    wr(A_ST, 8'h80);
    // The launch is counted at the access edge; look once it has settled
    @(negedge clk);
    check(n_launch, 1);
    ev(6'h20);
    rd(A_ST, 8'h08);
    check({31'h0, cc_irq}, 32'h0);
    wr(A_ST, 8'h80);
    wr(A_CF, 8'h8c);
    rd(A_CF, 8'h80);
    ev(6'h11);
    rd(A_ST, 8'h83);
    check({31'h0, cc_irq}, 32'h1);
    ev(6'h04);
    rd(A_ST, 8'ha3);
    wr(A_ST, 8'h80);
    wr(A_ST, 8'h00);
    rd(A_ST, 8'ha3);
    check(n_launch, 1);
    wr(A_ST, 8'h20);
    ev(6'h02);
    rd(A_ST, 8'h93);
    check({31'h0, seq_ok}, 32'h0);
    wr(A_ST, 8'h80);
    check(n_launch, 1);
    wr(A_ST, 8'h10);
    @(negedge clk);
    check({31'h0, seq_ok}, 32'h1);
    wr(A_ST, 8'h80);
    ev(6'h20);
    rd(A_ST, 8'h08);
    ev(6'h10);
    rd(A_ST, 8'h80);
    // ----------------------------------------
    // Forced and detected array faults
    // ----------------------------------------
    wr(A_EC, 8'h01);
    wr(A_CF, 8'h01);
    fread(1'b0, 1'b0);
    rd(A_ES, 8'h01);
    check({31'h0, sf_irq}, 32'h1);
    wr(A_ES, 8'h00);
    rd(A_ES, 8'h01);
    rd(A_CF, 8'h01);
    wr(A_EC, 8'h00);
    @(negedge clk);
    check({31'h0, sf_irq}, 32'h0);
    wr(A_CF, 8'h0e);
    wr(A_ES, 8'h01);
    fread(1'b0, 1'b0);
    rd(A_ES, 8'h02);
    wr(A_CF, 8'h10);
    wr(A_ES, 8'h02);
    fread(1'b1, 1'b1);
    rd(A_ES, 8'h02);
    wr(A_CF, 8'h00);
    wr(A_ES, 8'h03);
    fread(1'b1, 1'b0);
    rd(A_ES, 8'h01);
    wr(12'h020, 8'($urandom()));
    rd(12'h020, 8'h00);
    // Enable dropped in mid-access stretches the transfer
    wr(A_CF, 8'h9c);
    fork
      rd(A_CF, 8'h9c);
      begin
        repeat (2) @(posedge clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    rst_b <= 1'b0;
    seq_err <= 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(A_CF, 8'h00);
    rd(A_ST, 8'h81);
    final_report;
  end
endmodule
